// ### core/rbp_calib_div.sv
`timescale 1ns/100ps
`default_nettype none

module rbp_calib_div #(
    parameter int CNT_W = rbp_pkg::CAL_CNT_W,
    parameter int FAST_HALF = rbp_pkg::CAL_FAST_HALF,
    parameter int SLOW_HALF = rbp_pkg::CAL_SLOW_HALF
) (
    input wire logic clk,         // system clock
    input wire logic arst_n,      // async reset, active low
    input wire logic enable,      // run the divider
    input wire logic slow_sel,    // 1: slow rate, 0: fast rate
    input wire logic lse_tick,    // one pulse per low-speed clock period
    output logic calib_ff         // divided calibration clock
);

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic nxt_calib;
    wire [CNT_W-1:0] half_last = slow_sel ? CNT_W'(SLOW_HALF - 1) : CNT_W'(FAST_HALF - 1);
    wire wrap = lse_tick && (cnt_ff >= half_last);

    // stopping clears the phase: a restart begins with a full low half
    assign nxt_cnt = !enable ? '0 : wrap ? '0 : lse_tick ? cnt_ff + CNT_W'(1) : cnt_ff; // see RULE5
    assign nxt_calib = !enable ? 1'b0 : wrap ? !calib_ff : calib_ff; // see RULE5

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= '0;
            calib_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            calib_ff <= nxt_calib;
        end
    end

endmodule

`default_nettype wire

// ### core/rbp_osc_pin.sv
`timescale 1ns/100ps
`default_nettype none

module rbp_osc_pin (
    input wire logic osc_enable,      // low_speed_osc_enable
    input wire logic osc_bypass,      // low_speed_osc_bypass
    input wire logic force_enable,    // pin force enable
    input wire logic force_value,     // pin value
    output logic pin_out,             // level to drive
    output logic pin_oe,              // drive enable, high while driving
    output rbp_pkg::rbp_osc_mode_e mode // decoded pin mode
);

    // oscillator ownership masks force and value entirely
    assign mode = osc_enable ? (osc_bypass ? rbp_pkg::OP_BYPASS : rbp_pkg::OP_XTAL) // see RULE10
                : force_enable ? rbp_pkg::OP_FORCE_PP : rbp_pkg::OP_GPIO; // see RULE11
    assign pin_oe = (mode == rbp_pkg::OP_FORCE_PP); // see RULE11
    assign pin_out = pin_oe & force_value; // see RULE11

endmodule

`default_nettype wire

// ### core/rbp_pin_ctrl.sv
// Overview of operation
// RULE1 - the clock output, timestamp input and tamper-one input share one pin under a fixed priority.
// RULE2 - an enabled alarm output wins the pin outright, open-drain for value 0 and push-pull for value 1.
// RULE3 - the alarm-A event appears on the clock output only when the source select picks the alarm.
// RULE4 - with the alarm off and calibration output on, the calibration clock drives the pin push-pull.
// RULE5 - from a 32.768kHz low-speed clock the calibration output runs at 512Hz or 1Hz as selected.
// RULE6 - with both outputs off, an enabled timestamp or tamper-one input makes the pin a floating input, timestamp first.
// RULE7 - with no function claiming the pin and force enabled, the pin is driven push-pull with the value bit.
// RULE8 - forced mode and its level are held unchanged through standby.
// RULE9 - with nothing enabled the pin is released to ordinary gpio or wake-up use.
// RULE10 - while the low-speed oscillator is enabled both oscillator pins belong to it and their force bits are ignored.
// RULE11 - with the oscillator off, a forced oscillator pin is driven push-pull with its value, else left as gpio.
// RULE12 - pin selection is a plain decode of the retained configuration bits with no added latency beyond the output flop.
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none

module rbp_pin_ctrl #(
    parameter int CAL_CNT_W = rbp_pkg::CAL_CNT_W,
    parameter int CAL_FAST_HALF = rbp_pkg::CAL_FAST_HALF,
    parameter int CAL_SLOW_HALF = rbp_pkg::CAL_SLOW_HALF
) (
    input wire logic clk,                 // system clock, 100 MHz
    input wire logic arst_n,              // async reset, active low
    // apb slave
    input wire logic psel,                // apb select
    input wire logic penable,             // apb access phase
    input wire logic pwrite,              // apb direction, 1 = write
    input wire logic [11:0] paddr,        // apb byte address
    input wire logic [31:0] pwdata,       // apb write data
    input wire logic [3:0] pstrb,         // apb byte strobes
    output logic pready,                  // apb ready
    output logic [31:0] prdata,           // apb read data
    output logic pslverr,                 // apb error, unmapped address
    // rtc core side
    input wire logic alarm_a_event,       // alarm-a level from the calendar
    input wire logic lse_tick,            // one pulse per low-speed clock period
    input wire logic standby,             // system in standby
    output logic timestamp_in,            // shared pin level to the timestamp unit
    output logic tamper_one_in,           // shared pin level to the tamper unit
    output logic calibration_clock_out,   // calibration clock as driven
    // shared rtc pin
    input wire logic shared_rtc_pin_in,   // pad input level
    output logic shared_rtc_pin_out,      // pad output level
    output logic shared_rtc_pin_oe,       // pad drive enable
    output logic shared_rtc_pin_gpio,     // pad handed to gpio / wake-up
    // oscillator pins
    output logic osc_in_pin_out,          // osc-in pad output level
    output logic osc_in_pin_oe,           // osc-in pad drive enable
    output logic osc_in_pin_gpio,         // osc-in pad handed to gpio
    output logic osc_out_pin_out,         // osc-out pad output level
    output logic osc_out_pin_oe,          // osc-out pad drive enable
    output logic osc_out_pin_gpio,        // osc-out pad handed to gpio
    output logic low_speed_osc_run,       // oscillator owns both pads
    output logic low_speed_osc_bypass_on  // oscillator in bypass
);

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic [5:0] ctrl_ff;
    logic [5:0] cfg_ff;
    logic [1:0] osc_ff;
    logic [5:0] nxt_ctrl;
    logic [5:0] nxt_cfg;
    logic [1:0] nxt_osc;

    wire [1:0] clock_output_source_select = ctrl_ff[rbp_pkg::CTRL_SRC_LSB +: rbp_pkg::CTRL_SRC_W];
    wire calib_out_enable = ctrl_ff[rbp_pkg::CTRL_CAL_EN];
    wire calib_slow = ctrl_ff[rbp_pkg::CTRL_CAL_SLOW];
    wire ts_enable = ctrl_ff[rbp_pkg::CTRL_TS_EN];
    wire tamp_enable = ctrl_ff[rbp_pkg::CTRL_TAMP_EN];
    wire shared_pin_value = cfg_ff[rbp_pkg::CFG_SH_VAL];
    wire shared_pin_force_enable = cfg_ff[rbp_pkg::CFG_SH_FORCE];
    wire osc_in_pin_force_enable = cfg_ff[rbp_pkg::CFG_IN_FORCE];
    wire osc_in_pin_value = cfg_ff[rbp_pkg::CFG_IN_VAL];
    wire osc_out_pin_force_enable = cfg_ff[rbp_pkg::CFG_OUT_FORCE];
    wire osc_out_pin_value = cfg_ff[rbp_pkg::CFG_OUT_VAL];
    wire low_speed_osc_enable = osc_ff[rbp_pkg::OSC_EN];
    wire low_speed_osc_bypass = osc_ff[rbp_pkg::OSC_BYP];

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [31:0] rd_word;
    logic [31:0] status_word;

    // one wait state so read data comes from a flop
    wire access = psel && penable;
    wire done = access && pready_ff;
    wire sel_ctrl = (paddr == rbp_pkg::OFF_PIN_CTRL);
    wire sel_cfg = (paddr == rbp_pkg::OFF_PIN_CFG);
    wire sel_osc = (paddr == rbp_pkg::OFF_OSC_CTRL);
    wire sel_status = (paddr == rbp_pkg::OFF_STATUS);
    wire mapped = sel_ctrl || sel_cfg || sel_osc || sel_status;
    wire wr_lane0 = done && pwrite && pstrb[0];

    assign nxt_ctrl = (wr_lane0 && sel_ctrl) ? pwdata[5:0] : ctrl_ff;
    assign nxt_cfg = (wr_lane0 && sel_cfg) ? pwdata[5:0] : cfg_ff;
    assign nxt_osc = (wr_lane0 && sel_osc) ? pwdata[1:0] : osc_ff;

    assign rd_word = sel_ctrl ? {26'h0, ctrl_ff}
                   : sel_cfg ? {26'h0, cfg_ff}
                   : sel_osc ? {30'h0, osc_ff}
                   : sel_status ? status_word
                   : 32'h0;

    // ----------------------------------------------------------------
    // calibration clock
    // ----------------------------------------------------------------
    logic calib_clk;
    wire alarm_out_enable = (clock_output_source_select == rbp_pkg::SRC_ALARM_A); // see RULE3
    // the divider only runs while its output can reach the pad
    wire calib_run = calib_out_enable && !alarm_out_enable; // see RULE4

    rbp_calib_div #(
        .CNT_W(CAL_CNT_W),
        .FAST_HALF(CAL_FAST_HALF),
        .SLOW_HALF(CAL_SLOW_HALF)
    ) u_calib_div (
        .clk(clk),
        .arst_n(arst_n),
        .enable(calib_run),
        .slow_sel(calib_slow),
        .lse_tick(lse_tick),
        .calib_ff(calib_clk)
    );

    // ----------------------------------------------------------------
    // shared pin priority decode
    // ----------------------------------------------------------------
    rbp_pkg::rbp_sh_mode_e sh_mode;
    logic sh_out;
    logic sh_oe;

    // standby is deliberately absent here: state lives in flops that standby never touches
    assign sh_mode = alarm_out_enable ? (shared_pin_value ? rbp_pkg::SH_ALARM_PP : rbp_pkg::SH_ALARM_OD) // see RULE2
                   : calib_out_enable ? rbp_pkg::SH_CALIB_PP // see RULE4
                   : ts_enable ? rbp_pkg::SH_TS_IN // see RULE6
                   : tamp_enable ? rbp_pkg::SH_TAMP_IN // see RULE6
                   : shared_pin_force_enable ? rbp_pkg::SH_FORCE_PP // see RULE7
                   : rbp_pkg::SH_GPIO; // see RULE9

    always_comb begin
        sh_out = 1'b0;
        sh_oe = 1'b0;
        case (sh_mode)
            rbp_pkg::SH_ALARM_OD: begin
                // open drain pulls low while the alarm level is low
                sh_out = 1'b0;
                sh_oe = !alarm_a_event; // see RULE2
            end
            rbp_pkg::SH_ALARM_PP: begin
                sh_out = alarm_a_event; // see RULE2
                sh_oe = 1'b1;
            end
            rbp_pkg::SH_CALIB_PP: begin
                sh_out = calib_clk; // see RULE4
                sh_oe = 1'b1;
            end
            rbp_pkg::SH_FORCE_PP: begin
                sh_out = shared_pin_value; // see RULE7
                sh_oe = 1'b1; // see RULE8
            end
            default: begin
                sh_out = 1'b0;
                sh_oe = 1'b0;
            end
        endcase
    end

    // inputs see the pad only while the pin is floating input
    wire in_mode = (sh_mode == rbp_pkg::SH_TS_IN) || (sh_mode == rbp_pkg::SH_TAMP_IN); // see RULE6
    wire ts_level = in_mode && ts_enable && shared_rtc_pin_in; // see RULE1
    wire tamp_level = in_mode && tamp_enable && shared_rtc_pin_in; // see RULE1
    wire sh_gpio = (sh_mode == rbp_pkg::SH_GPIO); // see RULE9

    // ----------------------------------------------------------------
    // oscillator pins
    // ----------------------------------------------------------------
    logic in_out;
    logic in_oe;
    logic out_out;
    logic out_oe;
    rbp_pkg::rbp_osc_mode_e in_mode_dec;
    rbp_pkg::rbp_osc_mode_e out_mode_dec;

    rbp_osc_pin u_osc_in (
        .osc_enable(low_speed_osc_enable),
        .osc_bypass(low_speed_osc_bypass),
        .force_enable(osc_in_pin_force_enable),
        .force_value(osc_in_pin_value),
        .pin_out(in_out),
        .pin_oe(in_oe),
        .mode(in_mode_dec)
    );

    rbp_osc_pin u_osc_out (
        .osc_enable(low_speed_osc_enable),
        .osc_bypass(low_speed_osc_bypass),
        .force_enable(osc_out_pin_force_enable),
        .force_value(osc_out_pin_value),
        .pin_out(out_out),
        .pin_oe(out_oe),
        .mode(out_mode_dec)
    );

    assign status_word = {22'h0, calib_clk, standby, shared_rtc_pin_in,
                          out_mode_dec, in_mode_dec, sh_mode};

    // ----------------------------------------------------------------
    // state and output flops
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_ff <= rbp_pkg::CTRL_RST;
            cfg_ff <= rbp_pkg::CFG_RST;
            osc_ff <= rbp_pkg::OSC_RST;
        end else begin
            ctrl_ff <= nxt_ctrl;
            cfg_ff <= nxt_cfg;
            osc_ff <= nxt_osc;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= access && !pready_ff;
            pslverr_ff <= access && !pready_ff && !mapped;
            prdata_ff <= (access && !pready_ff && !pwrite) ? rd_word : 32'h0;
        end
    end

    // every top output comes from a flop
    logic sh_out_ff;
    logic sh_oe_ff;
    logic sh_gpio_ff;
    logic ts_ff;
    logic tamp_ff;
    logic cal_ff;
    logic in_out_ff;
    logic in_oe_ff;
    logic in_gpio_ff;
    logic out_out_ff;
    logic out_oe_ff;
    logic out_gpio_ff;
    logic osc_run_ff;
    logic osc_byp_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sh_out_ff <= 1'b0;
            sh_oe_ff <= 1'b0;
            sh_gpio_ff <= 1'b1;
            ts_ff <= 1'b0;
            tamp_ff <= 1'b0;
            cal_ff <= 1'b0;
        end else begin
            sh_out_ff <= sh_out; // see RULE12
            sh_oe_ff <= sh_oe; // see RULE12
            sh_gpio_ff <= sh_gpio;
            ts_ff <= ts_level;
            tamp_ff <= tamp_level;
            cal_ff <= calib_run && calib_clk;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            in_out_ff <= 1'b0;
            in_oe_ff <= 1'b0;
            in_gpio_ff <= 1'b1;
            out_out_ff <= 1'b0;
            out_oe_ff <= 1'b0;
            out_gpio_ff <= 1'b1;
            osc_run_ff <= 1'b0;
            osc_byp_ff <= 1'b0;
        end else begin
            in_out_ff <= in_out; // see RULE11
            in_oe_ff <= in_oe; // see RULE11
            in_gpio_ff <= (in_mode_dec == rbp_pkg::OP_GPIO);
            out_out_ff <= out_out; // see RULE11
            out_oe_ff <= out_oe; // see RULE11
            out_gpio_ff <= (out_mode_dec == rbp_pkg::OP_GPIO);
            osc_run_ff <= low_speed_osc_enable; // see RULE10
            osc_byp_ff <= low_speed_osc_enable && low_speed_osc_bypass; // see RULE10
        end
    end

    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata = prdata_ff;
    assign shared_rtc_pin_out = sh_out_ff;
    assign shared_rtc_pin_oe = sh_oe_ff;
    assign shared_rtc_pin_gpio = sh_gpio_ff;
    assign timestamp_in = ts_ff;
    assign tamper_one_in = tamp_ff;
    assign calibration_clock_out = cal_ff;
    assign osc_in_pin_out = in_out_ff;
    assign osc_in_pin_oe = in_oe_ff;
    assign osc_in_pin_gpio = in_gpio_ff;
    assign osc_out_pin_out = out_out_ff;
    assign osc_out_pin_oe = out_oe_ff;
    assign osc_out_pin_gpio = out_gpio_ff;
    assign low_speed_osc_run = osc_run_ff;
    assign low_speed_osc_bypass_on = osc_byp_ff;

endmodule

`default_nettype wire

// ### pkg/rbp_pkg.sv
package rbp_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses on apb)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_PIN_CTRL = 12'h000;
    localparam logic [11:0] OFF_PIN_CFG = 12'h004;
    localparam logic [11:0] OFF_OSC_CTRL = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00c;

    // ----------------------------------------------------------------
    // pin_ctrl fields
    // ----------------------------------------------------------------
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_SRC_W = 2;
    localparam int CTRL_CAL_EN = 2;
    localparam int CTRL_CAL_SLOW = 3;
    localparam int CTRL_TS_EN = 4;
    localparam int CTRL_TAMP_EN = 5;
    localparam logic [5:0] CTRL_RST = 6'h00;

    // clock_output_source_select encodings
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_ALARM_A = 2'h1;

    // ----------------------------------------------------------------
    // pin_cfg fields
    // ----------------------------------------------------------------
    localparam int CFG_SH_VAL = 0;
    localparam int CFG_SH_FORCE = 1;
    localparam int CFG_IN_FORCE = 2;
    localparam int CFG_IN_VAL = 3;
    localparam int CFG_OUT_FORCE = 4;
    localparam int CFG_OUT_VAL = 5;
    localparam logic [5:0] CFG_RST = 6'h00;

    // ----------------------------------------------------------------
    // osc_ctrl fields
    // ----------------------------------------------------------------
    localparam int OSC_EN = 0;
    localparam int OSC_BYP = 1;
    localparam logic [1:0] OSC_RST = 2'h0;

    // ----------------------------------------------------------------
    // status fields
    // ----------------------------------------------------------------
    localparam int ST_SH_MODE_LSB = 0;
    localparam int ST_IN_MODE_LSB = 3;
    localparam int ST_OUT_MODE_LSB = 5;
    localparam int ST_PIN_LVL = 7;
    localparam int ST_STANDBY = 8;
    localparam int ST_CAL_LVL = 9;

    // ----------------------------------------------------------------
    // calibration output timing, in low-speed clock ticks
    // ----------------------------------------------------------------
    localparam int LSE_HZ = 32768;
    localparam int CAL_FAST_HZ = 512;
    localparam int CAL_SLOW_HZ = 1;
    localparam int CAL_FAST_HALF = LSE_HZ / (2 * CAL_FAST_HZ);
    localparam int CAL_SLOW_HALF = LSE_HZ / (2 * CAL_SLOW_HZ);
    localparam int CAL_CNT_W = 15;

    // ----------------------------------------------------------------
    // pin modes, gray along the priority order
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SH_ALARM_OD = 3'h0,
        SH_ALARM_PP = 3'h1,
        SH_CALIB_PP = 3'h3,
        SH_TS_IN = 3'h2,
        SH_TAMP_IN = 3'h6,
        SH_FORCE_PP = 3'h7,
        SH_GPIO = 3'h5
    } rbp_sh_mode_e;

    typedef enum logic [1:0] {
        OP_XTAL = 2'h0,
        OP_BYPASS = 2'h1,
        OP_FORCE_PP = 2'h3,
        OP_GPIO = 2'h2
    } rbp_osc_mode_e;

endpackage

// ### sim/rbp_pad_model.sv
`timescale 1ns/100ps
`default_nettype none
module rbp_pad_model (
    input wire logic clk, // clock
    input wire logic pin_out, // design level
    input wire logic pin_oe, // design drives
    input wire logic src_en, // external source drives
    input wire logic src_level, // external level
    output logic pad // resolved pad
);
    logic idle_ff = 1'b0;
    // an undriven pad wanders so stale levels show
    always @(posedge clk) idle_ff <= ~idle_ff;
    assign pad = pin_oe ? pin_out : (src_en ? src_level : idle_ff);
endmodule
`default_nettype wire

// ### sim/rbp_pin_ctrl_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module rbp_pin_ctrl_monitor (
    input wire logic clk, // clock
    input wire logic arst_n, // reset
    input wire logic psel, // select
    input wire logic penable, // access
    input wire logic pready, // ready
    input wire logic [31:0] prdata, // read data
    input wire logic pslverr, // error
    input wire logic shared_rtc_pin_in, // pad level
    input wire logic shared_rtc_pin_oe, // pad drive
    input wire logic shared_rtc_pin_gpio, // pad released
    input wire logic timestamp_in, // ts level
    input wire logic tamper_one_in, // tamper level
    input wire logic osc_in_pin_oe, // osc-in drive
    input wire logic osc_in_pin_gpio, // osc-in released
    input wire logic osc_out_pin_oe, // osc-out drive
    input wire logic osc_out_pin_gpio, // osc-out released
    input wire logic low_speed_osc_run, // osc owns pads
    input wire logic low_speed_osc_bypass_on // bypass
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    AST_APB_WAIT: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("late pready");
    AST_APB_PULSE: assert property (pready |=> !pready)
        else $error("long pready");
    AST_APB_ERR: assert property (pslverr |-> pready)
        else $error("stray pslverr");
    AST_APB_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("idle prdata");
    AST_SH_EXCL: assert property (
        shared_rtc_pin_oe |-> !shared_rtc_pin_gpio && !timestamp_in && !tamper_one_in)
        else $error("driven pad shared");
    AST_TS_PAD: assert property (timestamp_in |-> $past(shared_rtc_pin_in))
        else $error("ts not pad");
    AST_TAMP_PAD: assert property (tamper_one_in |-> $past(shared_rtc_pin_in))
        else $error("tamper not pad");
    AST_OSC_OWN: assert property (low_speed_osc_run |->
        !(osc_in_pin_oe || osc_in_pin_gpio || osc_out_pin_oe || osc_out_pin_gpio))
        else $error("osc pads not owned");
    AST_OSC_BYP: assert property (low_speed_osc_bypass_on |-> low_speed_osc_run)
        else $error("bypass without enable");
    AST_OSC_FREE: assert property (!low_speed_osc_run |->
        (osc_in_pin_oe ^ osc_in_pin_gpio) && (osc_out_pin_oe ^ osc_out_pin_gpio))
        else $error("free osc pad state");
endmodule
`default_nettype wire

// ### sim/rtc_backup_pin_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
module rtc_backup_pin_control_bench;
    // ----
    // signals and instances
    // ----
    logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, err, timestamp_in, tamper_one_in, calibration_clock_out;
    logic alarm_a_event = 1'b0, lse_tick = 1'b0, standby = 1'b0, src_en = 1'b1, src_level = 1'b1;
    logic shared_rtc_pin_in, shared_rtc_pin_out, shared_rtc_pin_oe, shared_rtc_pin_gpio;
    logic osc_in_pin_out, osc_in_pin_oe, osc_in_pin_gpio, osc_out_pin_out, osc_out_pin_oe, osc_out_pin_gpio;
    logic low_speed_osc_run, low_speed_osc_bypass_on;
    logic [5:0] c;
    logic [2:0] m, ei, eo;
    int n_fail = 0, num_checks = 0, cyc = 0;
    // {pin_ctrl, pin_cfg, alarm, {oe,out,gpio}, mode}
    localparam logic [18:0] TBL [0:10] = '{{6'h00, 6'h00, 1'h0, 3'h1, 3'h5}, {6'h00, 6'h03, 1'h0, 3'h6, 3'h7},
        {6'h00, 6'h02, 1'h0, 3'h4, 3'h7}, {6'h20, 6'h03, 1'h0, 3'h0, 3'h6}, {6'h30, 6'h03, 1'h0, 3'h0, 3'h2},
        {6'h34, 6'h03, 1'h0, 3'h4, 3'h3}, {6'h35, 6'h03, 1'h1, 3'h6, 3'h1}, {6'h35, 6'h03, 1'h0, 3'h4, 3'h1},
        {6'h35, 6'h02, 1'h1, 3'h0, 3'h0}, {6'h35, 6'h02, 1'h0, 3'h4, 3'h0}, {6'h36, 6'h03, 1'h1, 3'h4, 3'h3}};
    always #5 clk = ~clk;
    rbp_pin_ctrl #(.CAL_FAST_HALF(2), .CAL_SLOW_HALF(8)) rbp_pin_ctrl_inst (.clk, .arst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .alarm_a_event, .lse_tick, .standby,
        .timestamp_in, .tamper_one_in, .calibration_clock_out, .shared_rtc_pin_in, .shared_rtc_pin_out,
        .shared_rtc_pin_oe, .shared_rtc_pin_gpio, .osc_in_pin_out, .osc_in_pin_oe, .osc_in_pin_gpio,
        .osc_out_pin_out, .osc_out_pin_oe, .osc_out_pin_gpio, .low_speed_osc_run, .low_speed_osc_bypass_on);
    rbp_pad_model rbp_pad_model_inst (.clk, .pin_out(shared_rtc_pin_out), .pin_oe(shared_rtc_pin_oe), .src_en,
        .src_level, .pad(shared_rtc_pin_in));
    // ----
    // tasks
    // ----
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // pads follow one edge after the completing edge
    task automatic settle;
        repeat (2) @(negedge clk);
    endtask
    task automatic cal_ticks(input int exp);
        logic s;
        int n = 0;
        s = calibration_clock_out;
        while (calibration_clock_out === s && n < 40) begin
            @(posedge clk);
            lse_tick <= 1'b1;
            @(posedge clk);
            lse_tick <= 1'b0;
            repeat (3) @(negedge clk);
            n++;
        end
        chk("cal ticks", exp, n);
        chk("cal level", {~s, ~s}, {calibration_clock_out, shared_rtc_pin_out});
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ----
    // tests
    // ----
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        apb(1'b0, rbp_pkg::OFF_PIN_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b1, rbp_pkg::OFF_OSC_CTRL, 32'hffffffff);
        apb(1'b0, rbp_pkg::OFF_OSC_CTRL, 32'h0);
        chk("osc ctrl", 32'h3, rd);
        pstrb <= 4'h0;
        apb(1'b1, rbp_pkg::OFF_PIN_CFG, 32'h3f);
        pstrb <= 4'hf;
        apb(1'b0, rbp_pkg::OFF_PIN_CFG, 32'h0);
        chk("strobe off write", 32'h0, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", 32'h1, {rd, err});
        apb(1'b1, rbp_pkg::OFF_OSC_CTRL, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 11; i++) begin
            alarm_a_event <= TBL[i][6];
            apb(1'b1, rbp_pkg::OFF_PIN_CFG, {26'h0, TBL[i][12:7]});
            apb(1'b1, rbp_pkg::OFF_PIN_CTRL, {26'h0, TBL[i][18:13]});
            settle();
            m = TBL[i][2:0];
            chk("shared pin", {TBL[i][5:3], m == 3'h2 && TBL[i][17], (m == 3'h2 || m == 3'h6) && TBL[i][18]},
                {shared_rtc_pin_oe, shared_rtc_pin_out & shared_rtc_pin_oe, shared_rtc_pin_gpio, timestamp_in,
                tamper_one_in});
            apb(1'b0, rbp_pkg::OFF_STATUS, 32'h0);
            chk("pin mode", {29'h0, m}, {29'h0, rd[2:0]});
        end
        apb(1'b1, rbp_pkg::OFF_PIN_CTRL, 32'h0);
        standby <= 1'b1;
        settle();
        chk("standby pin", 32'h6, {shared_rtc_pin_oe, shared_rtc_pin_out, shared_rtc_pin_gpio});
        apb(1'b0, rbp_pkg::OFF_STATUS, 32'h0);
        chk("standby status", 32'h1d7, {22'h0, rd[9:0]});
        standby <= 1'b0;
        $display("test shared pin done");
        for (int o = 0; o < 4; o++) begin
            for (int k = 0; k < 3; k++) begin
                c = (k == 0) ? 6'h3c : ((k == 1) ? 6'h14 : 6'h00);
                apb(1'b1, rbp_pkg::OFF_PIN_CFG, {26'h0, c});
                apb(1'b1, rbp_pkg::OFF_OSC_CTRL, o);
                settle();
                ei = o[0] ? 3'h0 : (c[2] ? {1'b1, c[3], 1'b0} : 3'h1);
                eo = o[0] ? 3'h0 : (c[4] ? {1'b1, c[5], 1'b0} : 3'h1);
                chk("osc pins", {ei, eo, o[0], o[0] & o[1]}, {osc_in_pin_oe, osc_in_pin_out & osc_in_pin_oe,
                    osc_in_pin_gpio, osc_out_pin_oe, osc_out_pin_out & osc_out_pin_oe, osc_out_pin_gpio,
                    low_speed_osc_run, low_speed_osc_bypass_on});
            end
        end
        $display("test oscillator pins done");
        apb(1'b1, rbp_pkg::OFF_PIN_CTRL, 32'h4);
        settle();
        cal_ticks(2);
        cal_ticks(2);
        apb(1'b1, rbp_pkg::OFF_PIN_CTRL, 32'h0);
        apb(1'b1, rbp_pkg::OFF_PIN_CTRL, 32'hc);
        settle();
        cal_ticks(8);
        $display("test calibration done");
        complete_run();
    end
endmodule
bind rbp_pin_ctrl rbp_pin_ctrl_monitor rbp_pin_ctrl_monitor_inst (.clk, .arst_n, .psel, .penable, .pready, .prdata,
    .pslverr, .shared_rtc_pin_in, .shared_rtc_pin_oe, .shared_rtc_pin_gpio, .timestamp_in, .tamper_one_in,
    .osc_in_pin_oe, .osc_in_pin_gpio, .osc_out_pin_oe, .osc_out_pin_gpio, .low_speed_osc_run,
    .low_speed_osc_bypass_on);
`default_nettype wire
